// ==== logic/qct_pkg.sv ====
// package: constants and types for the quad counter/timer clocking block
package qct_pkg;

  // ----------------------------------------------------------------
  // register indices and bus
  // ----------------------------------------------------------------
  localparam int          QCT_AW          = 4;
  localparam logic [3:0]  QCT_REG_TIMER_CLOCK_CONTROL_REG   = 4'h0;
  localparam logic [3:0]  QCT_REG_TCTRL   = 4'h1;
  localparam logic [3:0]  QCT_REG_TMODE   = 4'h2;
  localparam logic [3:0]  QCT_REG_T0      = 4'h3;
  localparam logic [3:0]  QCT_REG_T1      = 4'h4;
  localparam logic [3:0]  QCT_REG_T2      = 4'h5;
  localparam logic [3:0]  QCT_REG_T2RLD   = 4'h6;
  localparam logic [3:0]  QCT_REG_T3      = 4'h7;
  localparam logic [3:0]  QCT_REG_T3RLD   = 4'h8;
  localparam logic [3:0]  QCT_REG_T23CTL  = 4'h9;
  localparam logic [3:0]  QCT_REG_T2CAP   = 4'hA;
  localparam logic [3:0]  QCT_REG_T3CAP   = 4'hB;

  // ----------------------------------------------------------------
  // prescaler and divider figures
  // ----------------------------------------------------------------
  localparam logic [1:0]  QCT_SCA_DIV12   = 2'h0;
  localparam logic [1:0]  QCT_SCA_DIV4    = 2'h1;
  localparam logic [1:0]  QCT_SCA_DIV48   = 2'h2;
  localparam logic [1:0]  QCT_SCA_EXT8    = 2'h3;
  localparam logic [5:0]  QCT_DIV12       = 6'h0C;
  localparam logic [5:0]  QCT_DIV4        = 6'h04;
  localparam logic [5:0]  QCT_DIV48       = 6'h30;
  localparam logic [5:0]  QCT_DIV_SLOW8   = 6'h08;
  localparam logic [12:0] QCT_MAX13       = 13'h1FFF;

  // timer0/1 mode codes
  localparam logic [1:0]  QCT_M_13        = 2'h0;
  localparam logic [1:0]  QCT_M_16        = 2'h1;
  localparam logic [1:0]  QCT_M_RLD8      = 2'h2;
  localparam logic [1:0]  QCT_M_SPLIT     = 2'h3;

  // timer2/3 external clock choice
  localparam logic [1:0]  QCT_X_DIV12     = 2'h0;
  localparam logic [1:0]  QCT_X_SLOW8     = 2'h1;
  localparam logic [1:0]  QCT_X_CMP       = 2'h2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [QCT_AW-1:0] addr;
    logic [15:0]       wdata;
    logic              wr;
    logic              rd;
  } qct_bus_s;

  typedef struct packed {
    logic ext_count_input_zero;
    logic ext_count_input_one;
    logic external_gate_input_zero;
    logic external_gate_input_one;
    logic ext_clk;
    logic rtc_clk;
    logic cmp0;
    logic cmp1;
  } qct_pins_s;

  typedef struct packed {
    logic [15:0] timer0;
    logic [15:0] timer1;
    logic [15:0] timer2;
    logic [15:0] timer3;
  } qct_cnt_s;

endpackage

// ==== logic/qct_sync.sv ====
// module: two-stage synchroniser with falling edge and level outputs
`timescale 1ns/10ps
module qct_sync
  import qct_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } qct_sync_s;

  qct_sync_s st_ff;
  qct_sync_s nxt_st;

  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = din;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.s2;
  // previous high, current low; needs two-cycle levels from the source
  assign fall  = st_ff.s3 & ~st_ff.s2;

endmodule

// ==== logic/qct_top.sv ====
// module: four counter/timers with clock selection and register port
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
module qct_top
  import qct_pkg::*;
(
  input  wire logic      sys_clk,
  input  wire logic      rstn,
  input  wire qct_bus_s  bus,
  output logic [15:0]    rdata,
  input  wire qct_pins_s pins,
  output logic [3:0]     overflow,
  output qct_cnt_s       counts
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  timer_clock_control_reg;    // 7:4 t3h t3l t2h t2l, 3 t1 sysclk, 2 t0 sysclk, 1:0 prescale
    logic [7:0]  tctrl;    // 7 tf1, 6 tr1, 5 tf0, 4 tr0, 3:0 stored but unused
    logic [7:0]  tmode;    // 7 gate1, 6 c/t1, 5:4 mode1, 3 timer_zero_gate_enable, 2 c/t0, 1:0 mode0
    logic [15:0] t0;
    logic [15:0] t1;
    logic [15:0] t2;
    logic [15:0] t2rld;
    logic [15:0] t3;
    logic [15:0] t3rld;
    logic [15:0] t23ctl;   // per timer byte: 7 tfh 6 tfl 5 run 4 split 3 cap 2 - 1:0 xclk
    logic [15:0] t2cap;
    logic [15:0] t3cap;
    logic [5:0]  pre_cnt;
    logic        pre_tick;
    logic [3:0]  d12_cnt;
    logic        d12_tick;
    logic [15:0] rdata;
  } qct_st_s;

  qct_st_s st_ff;
  qct_st_s nxt_st;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [7:0] lvl;
  logic [7:0] fall;

  qct_sync #(.W(8)) u_sync (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .din     (pins),
    .level   (lvl),
    .fall    (fall)
  );

  // bit order follows qct_pins_s: 7 count0 ... 0 cmp1
  wire logic f_cnt0  = fall[7];
  wire logic f_cnt1  = fall[6];
  wire logic g0_lvl  = lvl[5];
  wire logic g1_lvl  = lvl[4];
  wire logic f_ext   = fall[3];
  wire logic f_rtc   = fall[2];
  wire logic f_cmp0  = fall[1];
  wire logic f_cmp1  = fall[0];

  // slow clocks divided by 8 on their own edges
  logic [2:0] ext8_ff;
  logic [2:0] rtc8_ff;
  wire logic ext8_tick = f_ext & (ext8_ff == 3'h7);
  wire logic rtc8_tick = f_rtc & (rtc8_ff == 3'h7);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ext8_ff <= 3'h0;
      rtc8_ff <= 3'h0;
    end else begin
      ext8_ff <= ext8_ff + {2'h0, f_ext};
      rtc8_ff <= rtc8_ff + {2'h0, f_rtc};
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] pre_div(input logic [1:0] sca);
    case (sca)
      QCT_SCA_DIV12: pre_div = QCT_DIV12;
      QCT_SCA_DIV4:  pre_div = QCT_DIV4;
      QCT_SCA_DIV48: pre_div = QCT_DIV48;
      default:       pre_div = QCT_DIV_SLOW8;
    endcase
  endfunction

  // timer2/3 source tick for a byte half
  function automatic logic t23_tick(input logic sysclk_sel, input logic [1:0] xclk,
                                    input logic d12, input logic slow8, input logic cmp);
    if (sysclk_sel) begin
      t23_tick = 1'b1;
    end else begin
      case (xclk)
        QCT_X_DIV12: t23_tick = d12;
        QCT_X_SLOW8: t23_tick = slow8;
        QCT_X_CMP:   t23_tick = cmp;
        default:     t23_tick = d12;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic [1:0]  inc01;
  logic [1:0]  run01;
  logic [15:0] tv;
  logic [15:0] nv;
  logic [1:0]  ovf;
  logic [7:0]  c;
  logic        tk_lo;
  logic        tk_hi;
  logic        cap_ev;
  logic [15:0] rv;
  logic [12:0] v13;
  logic        sp_ovf;

  always_comb begin
    nxt_st = st_ff;
    inc01  = '0;
    run01  = '0;
    tv     = '0;
    nv     = '0;
    ovf    = '0;
    c      = '0;
    tk_lo  = 1'b0;
    tk_hi  = 1'b0;
    cap_ev = 1'b0;
    rv     = '0;
    v13    = '0;
    sp_ovf = 1'b0;

    // shared prescaler for timer0/1; slow ext/8 source steps only on its own edges
    nxt_st.pre_tick = 1'b0;
    if (st_ff.timer_clock_control_reg[1:0] != QCT_SCA_EXT8 || ext8_tick) begin
      if (st_ff.pre_cnt >= pre_div(st_ff.timer_clock_control_reg[1:0]) - 6'h01) begin
        nxt_st.pre_cnt  = 6'h00;
        nxt_st.pre_tick = 1'b1;
      end else begin
        nxt_st.pre_cnt  = st_ff.pre_cnt + 6'h01;
      end
    end
    if (st_ff.timer_clock_control_reg[1:0] == QCT_SCA_EXT8) begin
      nxt_st.pre_tick = ext8_tick;
      nxt_st.pre_cnt  = 6'h00;
    end
    nxt_st.d12_tick = (st_ff.d12_cnt == 4'hB);
    nxt_st.d12_cnt  = (st_ff.d12_cnt == 4'hB) ? 4'h0 : st_ff.d12_cnt + 4'h1;

    // ------------------------------------------------------------
    // timer0 and timer1
    // ------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      c = (i == 0) ? {4'h0, st_ff.tmode[3:0]} : {4'h0, st_ff.tmode[7:4]};
      // gate and run
      run01[i] = st_ff.tctrl[4 + 2*i] &
                 (~c[3] | ((i == 0) ? g0_lvl : g1_lvl));
      if (c[2]) begin
        inc01[i] = (i == 0) ? f_cnt0 : f_cnt1;
      end else begin
        inc01[i] = st_ff.timer_clock_control_reg[2 + i] ? 1'b1 : st_ff.pre_tick;
      end
    end

    // split on timer1 stops it; timer0 high byte borrows timer1 run bit
    for (int i = 0; i < 2; i++) begin
      tv = (i == 0) ? st_ff.t0 : st_ff.t1;
      nv = tv;
      c  = (i == 0) ? {4'h0, st_ff.tmode[3:0]} : {4'h0, st_ff.tmode[7:4]};
      if (run01[i] && inc01[i]) begin
        case (c[1:0])
          QCT_M_13: begin
            // high byte on top of the five low bits; bits 7:5 are left alone
            v13      = {tv[15:8], tv[4:0]} + 13'h0001;
            nv[15:8] = v13[12:5];
            nv[4:0]  = v13[4:0];
            ovf[i]   = ({tv[15:8], tv[4:0]} == QCT_MAX13);
          end
          QCT_M_16: begin
            nv     = tv + 16'h0001;
            ovf[i] = (tv == 16'hFFFF);
          end
          QCT_M_RLD8: begin
            nv[7:0] = (tv[7:0] == 8'hFF) ? tv[15:8] : tv[7:0] + 8'h01;
            ovf[i]  = (tv[7:0] == 8'hFF);
          end
          default: begin
            if (i == 0) begin
              nv[7:0] = tv[7:0] + 8'h01;
              ovf[i]  = (tv[7:0] == 8'hFF);
            end
          end
        endcase
      end
      // timer0 split high byte: sysclk-or-prescale, timer1 run, flags tf1
      if (i == 0 && c[1:0] == QCT_M_SPLIT && st_ff.tctrl[6] &&
          (st_ff.timer_clock_control_reg[2] | st_ff.pre_tick)) begin
        nv[15:8] = tv[15:8] + 8'h01;
        if (tv[15:8] == 8'hFF) begin
          sp_ovf = 1'b1;
        end
      end
      if (i == 0) nxt_st.t0 = nv;
      else        nxt_st.t1 = nv;
    end

    // timer1 keeps counting while timer0 is split but cannot set tf1, matching the classic core
    if (st_ff.tmode[1:0] == QCT_M_SPLIT) begin
      ovf[1]    = 1'b0;
    end

    // ------------------------------------------------------------
    // timer2 and timer3
    // ------------------------------------------------------------
    for (int i = 0; i < 2; i++) begin
      c     = st_ff.t23ctl[8*i +: 8];
      tv    = (i == 0) ? st_ff.t2 : st_ff.t3;
      rv    = (i == 0) ? st_ff.t2rld : st_ff.t3rld;
      nv    = tv;
      tk_lo = t23_tick(st_ff.timer_clock_control_reg[4 + 2*i], c[1:0], st_ff.d12_tick,
                       (i == 0) ? rtc8_tick : ext8_tick, (i == 0) ? f_cmp0 : f_cmp1);
      tk_hi = t23_tick(st_ff.timer_clock_control_reg[5 + 2*i], c[1:0], st_ff.d12_tick,
                       (i == 0) ? rtc8_tick : ext8_tick, (i == 0) ? f_cmp0 : f_cmp1);
      // capture: sysclk-rate count latched on each falling edge of the measured clock
      cap_ev = (c[1:0] == QCT_X_CMP) ? ((i == 0) ? f_cmp0 : f_cmp1)
                                     : ((i == 0) ? f_rtc : f_ext);
      if (c[5]) begin
        if (c[3]) begin
          nv = tv + 16'h0001;
          if (cap_ev) begin
            if (i == 0) nxt_st.t2cap = tv;
            else        nxt_st.t3cap = tv;
            nxt_st.t23ctl[8*i + 7] = 1'b1;
          end
        end else if (c[4]) begin
          if (tk_lo) begin
            nv[7:0] = (tv[7:0] == 8'hFF) ? rv[7:0] : tv[7:0] + 8'h01;
            if (tv[7:0] == 8'hFF) nxt_st.t23ctl[8*i + 6] = 1'b1;
          end
          if (tk_hi) begin
            nv[15:8] = (tv[15:8] == 8'hFF) ? rv[15:8] : tv[15:8] + 8'h01;
            if (tv[15:8] == 8'hFF) nxt_st.t23ctl[8*i + 7] = 1'b1;
          end
        end else if (tk_lo) begin
          nv = (tv == 16'hFFFF) ? rv : tv + 16'h0001;
          if (tv == 16'hFFFF) nxt_st.t23ctl[8*i + 7] = 1'b1;
        end
      end
      if (i == 0) nxt_st.t2 = nv;
      else        nxt_st.t3 = nv;
    end

    // ------------------------------------------------------------
    // register writes; hardware flag set wins over software clear, except for a t23ctl flag that was already set
    // ------------------------------------------------------------
    if (bus.wr) begin
      case (bus.addr)
        QCT_REG_TIMER_CLOCK_CONTROL_REG:  nxt_st.timer_clock_control_reg  = bus.wdata[7:0];
        QCT_REG_TCTRL:  nxt_st.tctrl  = bus.wdata[7:0];
        QCT_REG_TMODE:  nxt_st.tmode  = bus.wdata[7:0];
        QCT_REG_T0:     nxt_st.t0     = bus.wdata;
        QCT_REG_T1:     nxt_st.t1     = bus.wdata;
        QCT_REG_T2:     nxt_st.t2     = bus.wdata;
        QCT_REG_T2RLD:  nxt_st.t2rld  = bus.wdata;
        QCT_REG_T3:     nxt_st.t3     = bus.wdata;
        QCT_REG_T3RLD:  nxt_st.t3rld  = bus.wdata;
        QCT_REG_T23CTL: nxt_st.t23ctl = bus.wdata | (nxt_st.t23ctl & 16'hC0C0 & ~st_ff.t23ctl);
        default: ;
      endcase
    end
    if (ovf[0]) nxt_st.tctrl[5] = 1'b1;
    if (ovf[1] | sp_ovf) nxt_st.tctrl[7] = 1'b1;

    // read data one cycle later; unmapped reads as zero
    nxt_st.rdata = 16'h0000;
    if (bus.rd) begin
      case (bus.addr)
        QCT_REG_TIMER_CLOCK_CONTROL_REG:  nxt_st.rdata = {8'h00, st_ff.timer_clock_control_reg};
        QCT_REG_TCTRL:  nxt_st.rdata = {8'h00, st_ff.tctrl};
        QCT_REG_TMODE:  nxt_st.rdata = {8'h00, st_ff.tmode};
        QCT_REG_T0:     nxt_st.rdata = st_ff.t0;
        QCT_REG_T1:     nxt_st.rdata = st_ff.t1;
        QCT_REG_T2:     nxt_st.rdata = st_ff.t2;
        QCT_REG_T2RLD:  nxt_st.rdata = st_ff.t2rld;
        QCT_REG_T3:     nxt_st.rdata = st_ff.t3;
        QCT_REG_T3RLD:  nxt_st.rdata = st_ff.t3rld;
        QCT_REG_T23CTL: nxt_st.rdata = st_ff.t23ctl;
        QCT_REG_T2CAP:  nxt_st.rdata = st_ff.t2cap;
        QCT_REG_T3CAP:  nxt_st.rdata = st_ff.t3cap;
        default:        nxt_st.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata         = st_ff.rdata;
  assign overflow      = {st_ff.t23ctl[15], st_ff.t23ctl[7], st_ff.tctrl[7], st_ff.tctrl[5]};
  assign counts.timer0 = st_ff.t0;
  assign counts.timer1 = st_ff.t1;
  assign counts.timer2 = st_ff.t2;
  assign counts.timer3 = st_ff.t3;

endmodule

// ==== test/qct_chk.sv ====
// checker: port-level timing relations of the quad counter/timer block
`timescale 1ns/10ps
module qct_chk
  import qct_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire qct_bus_s    bus,
  input wire logic [15:0] rdata,
  input wire qct_pins_s   pins,
  input wire logic [3:0]  overflow,
  input wire qct_cnt_s    counts
);
  // ------
  // shadow of the configuration seen on the bus
  // ------
  logic [7:0]  ck_ff;
  logic [7:0]  tc_ff;
  logic [7:0]  tm_ff;
  logic [15:0] x_ff;
  logic        p_ff;
  logic [4:0]  fh_ff;
  wire  [12:0] c13  = {counts.timer0[15:8], counts.timer0[4:0]};
  wire         m16  = tm_ff[1:0] == QCT_M_16 && tc_ff[4] && !tm_ff[3];
  wire         cnt0 = m16 && tm_ff[2];
  wire         sys0 = m16 && !tm_ff[2] && ck_ff[2];
  wire         div4 = m16 && !tm_ff[2] && !ck_ff[2] && ck_ff[1:0] == QCT_SCA_DIV4;
  wire         m13  = tm_ff[1:0] == QCT_M_13;
  wire         t2s  = x_ff[5:3] == 3'h4 && ck_ff[4];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {ck_ff, tc_ff, tm_ff, x_ff, p_ff, fh_ff} <= '0;
    end else begin
      p_ff  <= pins.ext_count_input_zero;
      // raw falls kept for a few cycles: the synchroniser delays the count
      fh_ff <= {fh_ff[3:0], p_ff & ~pins.ext_count_input_zero};
      if (bus.wr && bus.addr == QCT_REG_TIMER_CLOCK_CONTROL_REG) ck_ff <= bus.wdata[7:0];
      if (bus.wr && bus.addr == QCT_REG_TCTRL) tc_ff <= bus.wdata[7:0];
      if (bus.wr && bus.addr == QCT_REG_TMODE) tm_ff <= bus.wdata[7:0];
      if (bus.wr && bus.addr == QCT_REG_T23CTL) x_ff <= bus.wdata;
    end
  end

  // ------
  // assertions
  // ------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence wrap13_s;
    (m13 && c13 == 13'h1FFF && !bus.wr) ##1 (c13 == 13'h0000);
  endsequence
  sequence stop_s;
    (!tc_ff[4] && tm_ff[1:0] != QCT_M_SPLIT && !bus.wr)[*3];
  endsequence

  cnt_edge_a: assert property (
    cnt0 && !$past(bus.wr) && $changed(counts.timer0)
    |-> counts.timer0 == $past(counts.timer0) + 16'h1 && |fh_ff)
    else $error("timer0 counted without an input fall");
  sys_rate_a: assert property (
    (sys0 && !bus.wr) ##1 sys0 |-> counts.timer0 == $past(counts.timer0) + 16'h1)
    else $error("timer0 missed a system clock tick");
  div4_gap_a: assert property (
    div4 && $changed(counts.timer0) && !$past(bus.wr)
    |=> ($stable(counts.timer0) || $past(bus.wr) || $past(bus.wr, 2))[*3])
    else $error("timer0 ticked faster than one in four");
  gate_hold_a: assert property (
    (tc_ff[4] && tm_ff[3] && !pins.external_gate_input_zero && !bus.wr)[*4]
    |-> $stable(counts.timer0))
    else $error("timer0 ran with its gate closed");
  run_stop_a: assert property (stop_s |-> $stable(counts.timer0))
    else $error("timer0 ran with its run bit clear");
  t1_idle_a: assert property (
    (tm_ff[5:4] == QCT_M_SPLIT && !bus.wr)[*3] |-> $stable(counts.timer1))
    else $error("timer1 counted in split mode");
  wrap_flag_a: assert property (wrap13_s |-> overflow[0])
    else $error("13-bit wrap without overflow flag");
  t2_sys_a: assert property (
    (t2s && !bus.wr) ##1 t2s
    |-> counts.timer2 == $past(counts.timer2) + 16'h1 || $past(counts.timer2) == 16'hFFFF)
    else $error("timer2 missed a system clock tick");
endmodule

bind qct_top qct_chk u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .bus(bus), .rdata(rdata),
  .pins(pins), .overflow(overflow), .counts(counts)
);

// ==== test/qct_far.sv ====
// far-side model: count sources, gate level, slow clocks and comparators
`timescale 1ns/10ps
module qct_far
  import qct_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic en0,
  input  wire logic en1,
  input  wire logic timer_zero_gate_enable,
  output qct_pins_s pins
);
  logic [1:0] ph0 = 2'h0;
  logic [1:0] ph1 = 2'h0;
  logic [2:0] sl  = 3'h0;

  // two cycles per level: the fastest legal rate, one fall in four cycles
  always @(posedge sys_clk) begin
    if (en0) ph0 <= ph0 + 2'h1;
    if (en1) ph1 <= ph1 + 2'h1;
    sl <= (sl == 3'h5) ? 3'h0 : sl + 3'h1;
  end

  // slow sources all have a six cycle period
  always_comb begin
    pins.ext_count_input_zero     = ~ph0[1];
    pins.ext_count_input_one      = ~ph1[1];
    pins.external_gate_input_zero = timer_zero_gate_enable;
    pins.external_gate_input_one  = timer_zero_gate_enable;
    pins.ext_clk                  = sl < 3'h3;
    pins.rtc_clk                  = sl < 3'h3;
    pins.cmp0                     = sl < 3'h2;
    pins.cmp1                     = sl > 3'h2;
  end
endmodule

// ==== test/test_quad_counter_timer_clocking.sv ====
// testbench: register-driven checks of the quad counter/timer block
`timescale 1ns/10ps
module test_quad_counter_timer_clocking;
  import qct_pkg::*;
  logic        sys_clk     = 1'b0;
  logic        rstn        = 1'b0;
  qct_bus_s    bus         = '0;
  logic        en0         = 1'b0;
  logic        en1         = 1'b0;
  logic        gt0         = 1'b0;
  logic [15:0] rdata;
  qct_pins_s   pins;
  logic [3:0]  overflow;
  qct_cnt_s    counts;
  logic [15:0] d0, d1, d2, d3;
  int          miscompares = 0;
  int          n_tests     = 0;
  logic [15:0] ck [6]      = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h000A};
  logic [15:0] e0 [6]      = '{16'h0028, 16'h0078, 16'h000A, 16'h000A, 16'h01E0, 16'h000A};
  logic [15:0] e1 [6]      = '{16'h0028, 16'h0078, 16'h000A, 16'h000A, 16'h0078, 16'h01E0};
  logic [15:0] xk [4]      = '{16'h0000, 16'h0000, 16'h0000, 16'h0050};
  logic [15:0] xc [4]      = '{16'h2020, 16'h2121, 16'h2222, 16'h2020};
  logic [15:0] xe [4]      = '{16'h0028, 16'h000A, 16'h0050, 16'h01E0};

  always #5 sys_clk = ~sys_clk;

  qct_top DUT (.sys_clk(sys_clk), .rstn(rstn), .bus(bus), .rdata(rdata), .pins(pins),
               .overflow(overflow), .counts(counts));
  qct_far FAR (.sys_clk(sys_clk), .en0(en0), .en1(en1), .timer_zero_gate_enable(gt0), .pins(pins));

  // ------
  // bus tasks and comparison
  // ------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge sys_clk);
    bus.wr    <= 1'b0;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    @(posedge sys_clk);
    bus.rd   <= 1'b0;
    @(negedge sys_clk);
    chk(rdata, exp);
  endtask

  // settle first: a divider switch may leave one odd-length tick
  task automatic rate(input int w);
    qct_cnt_s s;
    repeat (100) @(negedge sys_clk);
    s = counts;
    repeat (w) @(negedge sys_clk);
    d0 = counts.timer0 - s.timer0;
    d1 = counts.timer1 - s.timer1;
    d2 = counts.timer2 - s.timer2;
    d3 = counts.timer3 - s.timer3;
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ------
  // tests
  // ------
  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(QCT_REG_T0, 16'h0000);
    wr(4'hC, 16'hFFFF);
    rd(4'hC, 16'h0000);
    wr(QCT_REG_T2RLD, 16'hA55A);
    rd(QCT_REG_T2RLD, 16'hA55A);
    wr(QCT_REG_T2RLD, 16'h0000);
    wr(QCT_REG_TMODE, 16'h0011);
    wr(QCT_REG_TCTRL, 16'h0050);
    foreach (ck[i]) begin
      wr(QCT_REG_TIMER_CLOCK_CONTROL_REG, ck[i]);
      rate(480);
      chk(d0, e0[i]);
      chk(d1, e1[i]);
    end
    wr(QCT_REG_TMODE, 16'h0055);
    wr(QCT_REG_TIMER_CLOCK_CONTROL_REG, 16'h000C);
    wr(QCT_REG_T0, 16'h0000);
    wr(QCT_REG_T1, 16'h0000);
    @(posedge sys_clk);
    en0 <= 1'b1;
    en1 <= 1'b1;
    repeat (40) @(posedge sys_clk);
    en1 <= 1'b0;
    repeat (60) @(posedge sys_clk);
    en0 <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rd(QCT_REG_T0, 16'h0019);
    rd(QCT_REG_T1, 16'h000A);
    wr(QCT_REG_TMODE, 16'h0009);
    wr(QCT_REG_TIMER_CLOCK_CONTROL_REG, 16'h0004);
    wr(QCT_REG_TCTRL, 16'h0010);
    rate(100);
    chk(d0, 16'h0000);
    @(posedge sys_clk);
    gt0 <= 1'b1;
    rate(100);
    chk(d0, 16'h0064);
    wr(QCT_REG_TCTRL, 16'h0000);
    rate(100);
    chk(d0, 16'h0000);
    wr(QCT_REG_TMODE, 16'h0000);
    wr(QCT_REG_T0, 16'hFF1C);
    wr(QCT_REG_TCTRL, 16'h0010);
    @(negedge sys_clk);
    chk({15'h0, overflow[0]}, 16'h0000);
    repeat (10) @(negedge sys_clk);
    chk({15'h0, overflow[0]}, 16'h0001);
    chk({8'h0, counts.timer0[15:8]}, 16'h0000);
    rd(QCT_REG_TCTRL, 16'h0030);
    wr(QCT_REG_TCTRL, 16'h0000);
    @(negedge sys_clk);
    chk({15'h0, overflow[0]}, 16'h0000);
    wr(QCT_REG_TMODE, 16'h0002);
    wr(QCT_REG_T0, 16'hF0FE);
    wr(QCT_REG_TCTRL, 16'h0010);
    rate(100);
    chk({8'h0, counts.timer0[15:8]}, 16'h00F0);
    chk({15'h0, overflow[0]}, 16'h0001);
    wr(QCT_REG_TMODE, 16'h0033);
    wr(QCT_REG_TIMER_CLOCK_CONTROL_REG, 16'h000C);
    wr(QCT_REG_TCTRL, 16'h0050);
    rate(100);
    chk({8'h0, d0[7:0]}, 16'h0064);
    chk(d1, 16'h0000);
    wr(QCT_REG_TCTRL, 16'h0000);
    foreach (xc[i]) begin
      wr(QCT_REG_TIMER_CLOCK_CONTROL_REG, xk[i]);
      wr(QCT_REG_T23CTL, xc[i]);
      rate(480);
      chk(d2, xe[i]);
      chk(d3, xe[i]);
    end
    wr(QCT_REG_T23CTL, 16'h002A);
    rate(20);
    chk({15'h0, overflow[2]}, 16'h0001);
    finish_test();
  end

  // the tests need about 7100 cycles; far beyond that means a hang
  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    finish_test();
  end
endmodule
